// file: epcfg_preload.sv
// Sequencer that copies preload words into the downstream port configuration bits.
`timescale 1ns/1ns
module epcfg_preload (
   input wire logic mclk,
   input wire logic rst,
   input wire logic mem_valid,
   output logic rd_req,
   output logic [7:0] rd_addr,
   input wire logic rd_ack,
   input wire logic [15:0] rd_data,
   output logic cfg_ready,
   output logic [2:0] slot_impl,
   output logic [2:0] slot_clk_cfg,
   output logic [2:0] dsi_req,
   output logic [2:0] low_priority_vc_count,
   output logic [8:0] port_num,
   output logic [20:0] tc_vc0_map
);
   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   epcfg_pkg::epcfg_state_t st_r, st_nxt;
   logic [1:0] idx_r, idx_nxt;
   logic req_r, req_nxt, rdy_r, rdy_nxt;
   logic [7:0] addr_r, addr_nxt;
   logic [2:0] load;

   // Byte address of the preload word for each downstream port.
   function automatic logic [7:0] port_addr(input logic [1:0] i);
      case (i)
         2'h0: port_addr = epcfg_pkg::ADDR_PORT2;
         2'h1: port_addr = epcfg_pkg::ADDR_PORT3;
         default: port_addr = epcfg_pkg::ADDR_PORT4;
      endcase
   endfunction

   always_comb begin
      st_nxt = st_r;
      idx_nxt = idx_r;
      req_nxt = 1'h0;
      rdy_nxt = rdy_r;
      addr_nxt = addr_r;
      load = 3'h0;
      case (st_r)
         epcfg_pkg::EPCFG_IDLE: begin
            if (mem_valid) begin
               st_nxt = epcfg_pkg::EPCFG_REQ;
               idx_nxt = 2'h0;
            end else begin
               st_nxt = epcfg_pkg::EPCFG_DONE;
               rdy_nxt = 1'h1;
            end
         end
         epcfg_pkg::EPCFG_REQ: begin
            addr_nxt = port_addr(idx_r);
            req_nxt = 1'h1;
            st_nxt = epcfg_pkg::EPCFG_WAIT;
         end
         epcfg_pkg::EPCFG_WAIT: begin
            if (rd_ack) begin
               load = 3'h1 << idx_r;
               if (idx_r == 2'(epcfg_pkg::NPORT - 1)) begin
                  st_nxt = epcfg_pkg::EPCFG_DONE;
                  rdy_nxt = 1'h1;
               end else begin
                  idx_nxt = idx_r + 2'h1;
                  st_nxt = epcfg_pkg::EPCFG_REQ;
               end
            end
         end
         epcfg_pkg::EPCFG_DONE: begin
            st_nxt = epcfg_pkg::EPCFG_DONE;
         end
         default: begin
            st_nxt = epcfg_pkg::EPCFG_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r <= epcfg_pkg::EPCFG_IDLE;
         idx_r <= 2'h0;
         req_r <= 1'h0;
         rdy_r <= 1'h0;
         addr_r <= 8'h00;
      end else begin
         st_r <= st_nxt;
         idx_r <= idx_nxt;
         req_r <= req_nxt;
         rdy_r <= rdy_nxt;
         addr_r <= addr_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rd_req = req_r;
   assign rd_addr = addr_r;
   assign cfg_ready = rdy_r;

   // ------------------------------------------------------------
   // Per-port fields
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < epcfg_pkg::NPORT; g++) begin : gen_port
         epcfg_port_fields u_fields (
            .mclk(mclk),
            .rst(rst),
            .load(load[g]),
            .word(rd_data),
            .def_pnum(3'(epcfg_pkg::DEF_PNUM0 + 3'(g))),
            .slot_impl(slot_impl[g]),
            .slot_clk_cfg(slot_clk_cfg[g]),
            .dsi_req(dsi_req[g]),
            .low_priority_vc_count(low_priority_vc_count[g]),
            .port_num(port_num[3*g+:3]),
            .tc_vc0_map(tc_vc0_map[7*g+:7])
         );

         // fields other than the port number move only on their own load.
         a_field_hold: assert property (@(posedge mclk) disable iff (rst)
            !load[g] |=> $stable({slot_impl[g], slot_clk_cfg[g], dsi_req[g],
            low_priority_vc_count[g], tc_vc0_map[7*g+:7]}))
            else $error("Field changed without a load.");

         // port number moves only on its own load once out of idle.
         a_pnum_hold: assert property (@(posedge mclk) disable iff (rst)
            (st_r != epcfg_pkg::EPCFG_IDLE && !load[g]) |=> $stable(port_num[3*g+:3]))
            else $error("Port number changed without a load.");

         // no memory leaves the defaults in place.
         a_field_default: assert property (@(posedge mclk) disable iff (rst)
            (st_r == epcfg_pkg::EPCFG_IDLE && !mem_valid) |=>
            (port_num[3*g+:3] == 3'(epcfg_pkg::DEF_PNUM0 + 3'(g)) &&
            tc_vc0_map[7*g+:7] == epcfg_pkg::DEF_TCMAP &&
            slot_impl[g] == epcfg_pkg::DEF_SLOT))
            else $error("Defaults not kept without memory.");
      end
   endgenerate

   // ------------------------------------------------------------
   // Sequencer checks
   // ------------------------------------------------------------
   // loads happen only before ready.
   a_no_late_load: assert property (@(posedge mclk) disable iff (rst)
      cfg_ready |-> load == 3'h0) else $error("Load after ready.");

   a_req_addr: assert property (@(posedge mclk) disable iff (rst)
      rd_req |-> (rd_addr == (idx_r == 2'h0 ? epcfg_pkg::ADDR_PORT2 :
      idx_r == 2'h1 ? epcfg_pkg::ADDR_PORT3 : epcfg_pkg::ADDR_PORT4)))
      else $error("Wrong preload address.");

   // no memory means ready on the next edge.
   a_nomem_ready: assert property (@(posedge mclk) disable iff (rst)
      (st_r == epcfg_pkg::EPCFG_IDLE && !mem_valid) |=> cfg_ready && !rd_req)
      else $error("Defaults path not ready.");

   a_ready_stays: assert property (@(posedge mclk) disable iff (rst)
      cfg_ready |=> cfg_ready) else $error("Ready dropped.");

   a_req_before_rdy: assert property (@(posedge mclk) disable iff (rst)
      cfg_ready |-> !rd_req) else $error("Request after ready.");

   a_req_pulse: assert property (@(posedge mclk) disable iff (rst)
      rd_req |=> !rd_req) else $error("Request longer than one cycle.");

   a_addr_hold: assert property (@(posedge mclk) disable iff (rst)
      !rd_req |-> $stable(rd_addr)) else $error("Address moved without a request.");

   // one port loads at a time, and only on an answer.
   a_load_onehot: assert property (@(posedge mclk) disable iff (rst)
      (load != 3'h0) |-> ($onehot(load) && rd_ack)) else $error("Bad load pattern.");

   // an answer while waiting is always taken.
   a_ack_loads: assert property (@(posedge mclk) disable iff (rst)
      (st_r == epcfg_pkg::EPCFG_WAIT && rd_ack) |-> load != 3'h0)
      else $error("Answer not taken.");

   // port 2 is followed by port 3.
   a_next_port3: assert property (@(posedge mclk) disable iff (rst)
      load[0] |-> ##2 (rd_req && rd_addr == epcfg_pkg::ADDR_PORT3))
      else $error("Port 3 not requested after port 2.");

   // port 3 is followed by port 4.
   a_next_port4: assert property (@(posedge mclk) disable iff (rst)
      load[1] |-> ##2 (rd_req && rd_addr == epcfg_pkg::ADDR_PORT4))
      else $error("Port 4 not requested after port 3.");

   a_rdy_after_last: assert property (@(posedge mclk) disable iff (rst)
      load[2] |=> cfg_ready) else $error("Ready late after last load.");

   // first request goes to port 2.
   a_first_port2: assert property (@(posedge mclk) disable iff (rst)
      (st_r == epcfg_pkg::EPCFG_IDLE && mem_valid) |=>
      !rd_req ##1 (rd_req && rd_addr == epcfg_pkg::ADDR_PORT2))
      else $error("First request not for port 2.");

   a_wait_holds: assert property (@(posedge mclk) disable iff (rst)
      (st_r == epcfg_pkg::EPCFG_WAIT && !rd_ack) |=>
      (st_r == epcfg_pkg::EPCFG_WAIT && !rd_req))
      else $error("Wait left without an answer.");

   a_mem_sample: assert property (@(posedge mclk) disable iff (rst)
      (st_r == epcfg_pkg::EPCFG_IDLE && mem_valid) |=>
      (st_r == epcfg_pkg::EPCFG_REQ && !cfg_ready))
      else $error("Memory present not seen.");

   a_idx_range: assert property (@(posedge mclk) disable iff (rst)
      idx_r != 2'h3) else $error("Port index out of range.");
endmodule

// file: epcfg_pkg.sv
// Constants for the downstream port configuration preload block.
package epcfg_pkg;
   localparam int NPORT = 3;
   localparam logic [7:0] ADDR_PORT2 = 8'h64;
   localparam logic [7:0] ADDR_PORT3 = 8'h66;
   localparam logic [7:0] ADDR_PORT4 = 8'h68;
   localparam logic [11:0] OFS_SLOT = 12'h0C0;
   localparam logic [11:0] OFS_SCLK = 12'h0D0;
   localparam logic [11:0] OFS_DSI = 12'h040;
   localparam logic [11:0] OFS_LOW_PRIORITY_VC_COUNT = 12'h144;
   localparam logic [11:0] OFS_PNUM = 12'h0CC;
   localparam logic [11:0] OFS_TCMAP = 12'h154;
   localparam int W_SLOT = 0;
   localparam int W_SCLK = 1;
   localparam int W_DSI = 2;
   localparam int W_LOW_PRIORITY_VC_COUNT = 3;
   localparam int W_PNUM_LO = 4;
   localparam int W_PNUM_HI = 6;
   localparam int W_TC_LO = 9;
   localparam int W_TC_HI = 15;
   localparam int D_SLOT = 24;
   localparam int D_SCLK = 28;
   localparam int D_DSI = 21;
   localparam int D_LOW_PRIORITY_VC_COUNT = 4;
   localparam int D_PNUM_LO = 24;
   localparam int D_TC_LO = 1;
   localparam logic DEF_SLOT = 1'h0;
   localparam logic DEF_SCLK = 1'h0;
   localparam logic DEF_DSI = 1'h0;
   localparam logic DEF_LOW_PRIORITY_VC_COUNT = 1'h0;
   localparam logic [2:0] DEF_PNUM0 = 3'h2;
   localparam logic [6:0] DEF_TCMAP = 7'h7F;
   typedef enum logic [1:0] {
      EPCFG_IDLE = 2'h0,
      EPCFG_REQ = 2'h1,
      EPCFG_WAIT = 2'h3,
      EPCFG_DONE = 2'h2
   } epcfg_state_t;
endpackage

// file: epcfg_port_fields.sv
// Holds the preloadable configuration bits of one downstream port.
`timescale 1ns/1ns
module epcfg_port_fields (
   input wire logic mclk,
   input wire logic rst,
   input wire logic load,
   input wire logic [15:0] word,
   input wire logic [2:0] def_pnum,
   output logic slot_impl,
   output logic slot_clk_cfg,
   output logic dsi_req,
   output logic low_priority_vc_count,
   output logic [2:0] port_num,
   output logic [6:0] tc_vc0_map
);
   logic slot_r, slot_nxt, sclk_r, sclk_nxt, dsi_r, dsi_nxt, low_priority_vc_count_r, low_priority_vc_count_nxt;
   logic [2:0] pnum_r, pnum_nxt;
   logic [6:0] tc_r, tc_nxt;
   logic pdef_r;

   always_comb begin
      slot_nxt = slot_r;
      sclk_nxt = sclk_r;
      dsi_nxt = dsi_r;
      low_priority_vc_count_nxt = low_priority_vc_count_r;
      pnum_nxt = pdef_r ? def_pnum : pnum_r;
      tc_nxt = tc_r;
      if (load) begin
         slot_nxt = word[epcfg_pkg::W_SLOT];
         sclk_nxt = word[epcfg_pkg::W_SCLK];
         dsi_nxt = word[epcfg_pkg::W_DSI];
         low_priority_vc_count_nxt = word[epcfg_pkg::W_LOW_PRIORITY_VC_COUNT];
         pnum_nxt = word[epcfg_pkg::W_PNUM_HI:epcfg_pkg::W_PNUM_LO];
         tc_nxt = word[epcfg_pkg::W_TC_HI:epcfg_pkg::W_TC_LO];
      end
   end

   // The port number default comes from a port input, so it is taken one edge after release.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         slot_r <= epcfg_pkg::DEF_SLOT;
         sclk_r <= epcfg_pkg::DEF_SCLK;
         dsi_r <= epcfg_pkg::DEF_DSI;
         low_priority_vc_count_r <= epcfg_pkg::DEF_LOW_PRIORITY_VC_COUNT;
         pnum_r <= 3'h0;
         tc_r <= epcfg_pkg::DEF_TCMAP;
         pdef_r <= 1'h1;
      end else begin
         slot_r <= slot_nxt;
         sclk_r <= sclk_nxt;
         dsi_r <= dsi_nxt;
         low_priority_vc_count_r <= low_priority_vc_count_nxt;
         pnum_r <= pnum_nxt;
         tc_r <= tc_nxt;
         pdef_r <= 1'h0;
      end
   end

   assign slot_impl = slot_r;
   assign slot_clk_cfg = sclk_r;
   assign dsi_req = dsi_r;
   assign low_priority_vc_count = low_priority_vc_count_r;
   assign port_num = pnum_r;
   assign tc_vc0_map = tc_r;

   a_pnum_load: assert property (@(posedge mclk) disable iff (rst)
      load |=> port_num == $past(word[6:4])) else $error("Port number not loaded.");
   a_tcmap_load: assert property (@(posedge mclk) disable iff (rst)
      load |=> tc_vc0_map == $past(word[15:9])) else $error("Traffic class map not loaded.");
   a_slot_load: assert property (@(posedge mclk) disable iff (rst)
      load |=> slot_impl == $past(word[0])) else $error("Slot bit not loaded.");
   a_sclk_load: assert property (@(posedge mclk) disable iff (rst)
      load |=> slot_clk_cfg == $past(word[1])) else $error("Slot clock bit not loaded.");
   a_dsi_load: assert property (@(posedge mclk) disable iff (rst)
      load |=> dsi_req == $past(word[2])) else $error("Initialization bit not loaded.");
   // low priority bit follows the word.
   a_low_priority_vc_count_load: assert property (@(posedge mclk) disable iff (rst)
      load |=> low_priority_vc_count == $past(word[3])) else $error("VC count bit not loaded.");
endmodule

// file: epcfg_mem_model.sv
// Behavioural model of the configuration memory answering preload reads.
`timescale 1ns/1ns
module epcfg_mem_model (
   input wire logic mclk,
   input wire logic rst,
   input wire logic rd_req,
   input wire logic [7:0] rd_addr,
   input wire logic [47:0] words,
   input wire logic [3:0] lat,
   output logic rd_ack,
   output logic [15:0] rd_data
);
   int wait_n = -1;
   logic [7:0] addr_r = 8'h00;
   initial rd_ack = 1'h0;
   initial rd_data = 16'h0000;
   function automatic logic [15:0] pick(input logic [7:0] a);
      case (a)
         8'h64: return words[15:0];
         8'h66: return words[31:16];
         8'h68: return words[47:32];
         default: return ~rd_data;
      endcase
   endfunction
   // Between answers the data lines toggle, so stale data cannot pass as a word.
   always @(negedge mclk) begin
      rd_ack <= (wait_n == 0) && !rst;
      rd_data <= (wait_n == 0) ? pick(addr_r) : ~rd_data;
      if (rst) begin
         wait_n <= -1;
      end else if (rd_req) begin
         wait_n <= lat;
         addr_r <= rd_addr;
      end else if (wait_n >= 0) begin
         wait_n <= wait_n - 1;
      end
   end
endmodule

// file: test_epcfg_preload.sv
// Self-checking bench for the downstream port preload block.
`timescale 1ns/1ns
module test_epcfg_preload;
   logic mclk = 1'h0;
   logic rst = 1'h1;
   logic mem_valid = 1'h0;
   logic [47:0] words = 48'h0;
   logic [3:0] lat = 4'h0;
   logic rd_req, rd_ack, cfg_ready;
   logic [7:0] rd_addr;
   logic [15:0] rd_data;
   logic [2:0] slot_impl, slot_clk_cfg, dsi_req, low_priority_vc_count;
   logic [8:0] port_num;
   logic [20:0] tc_vc0_map;
   int err_count = 0;
   int n_checks = 0;
   logic [7:0] seen[$];
   always #25 mclk = ~mclk;
   always @(negedge mclk) if (rd_req === 1'h1) seen.push_back(rd_addr);
   epcfg_preload u_dut (.mclk(mclk), .rst(rst), .mem_valid(mem_valid), .rd_req(rd_req),
      .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .cfg_ready(cfg_ready),
      .slot_impl(slot_impl), .slot_clk_cfg(slot_clk_cfg), .dsi_req(dsi_req),
      .low_priority_vc_count(low_priority_vc_count), .port_num(port_num),
      .tc_vc0_map(tc_vc0_map));
   epcfg_mem_model u_mem (.mclk(mclk), .rst(rst), .rd_req(rd_req), .rd_addr(rd_addr),
      .words(words), .lat(lat), .rd_ack(rd_ack), .rd_data(rd_data));
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic start(input logic mv);
      @(negedge mclk);
      rst = 1'h1;
      mem_valid = mv;
      seen.delete();
      repeat (12) @(negedge mclk);
      rst = 1'h0;
   endtask
   task automatic wait_ready();
      int i;
      for (i = 0; i < 200 && cfg_ready !== 1'h1; i++) @(negedge mclk);
      if (i == 200) begin
         err_count++;
         summarize();
      end
   endtask
   task automatic scen_load(input logic [47:0] w, input logic [3:0] l);
      logic [15:0] x;
      words = w;
      lat = l;
      start(1'h1);
      repeat (2) @(negedge mclk);
      check("ready early", 16'h0, {15'h0, cfg_ready});
      wait_ready();
      check("reads at ready", 16'h3, 16'(seen.size()));
      for (int g = 0; g < 3; g++) begin
         x = w[16*g +: 16];
         check("addr", 16'h64 + 16'(2*g), {8'h0, seen[g]});
         check("slot", {15'h0, x[0]}, {15'h0, slot_impl[g]});
         check("sclk", {15'h0, x[1]}, {15'h0, slot_clk_cfg[g]});
         check("dsi", {15'h0, x[2]}, {15'h0, dsi_req[g]});
         check("low_priority_vc_count", {15'h0, x[3]}, {15'h0, low_priority_vc_count[g]});
         check("pnum", {13'h0, x[6:4]}, {13'h0, port_num[3*g +: 3]});
         check("tcmap", {9'h0, x[15:9]}, {9'h0, tc_vc0_map[7*g +: 7]});
      end
      repeat (8) @(negedge mclk);
      check("reads", 16'h3, 16'(seen.size()));
      check("ready holds", 16'h1, {15'h0, cfg_ready});
   endtask
   task automatic scen_nomem();
      start(1'h0);
      repeat (2) @(negedge mclk);
      check("ready nomem", 16'h1, {15'h0, cfg_ready});
      wait_ready();
      repeat (8) @(negedge mclk);
      check("reads", 16'h0, 16'(seen.size()));
      for (int g = 0; g < 3; g++) begin
         check("pnum def", 16'(g + 2), {13'h0, port_num[3*g +: 3]});
         check("tc def", 16'(epcfg_pkg::DEF_TCMAP), {9'h0, tc_vc0_map[7*g +: 7]});
      end
      check("bits def", 16'h0, {4'h0, slot_impl, slot_clk_cfg, dsi_req,
         low_priority_vc_count});
   endtask
   initial begin
      scen_load(48'hFE7F_AA4A_0135, 4'h0);
      scen_load(48'h0000_55B5_FFFF, 4'h5);
      scen_nomem();
      summarize();
   end
endmodule
